/* File: src/acbd_decoder.v */
// Command byte decoder for a serial configured multichannel converter.
// How it works
// - Top bit one means conversion byte.
// - Bits six to three give channel N.
// - Bit zero requests temperature first in scan.
// - Scan code 00 converts channels 0..N.
// - Scan code 01 converts N up to top.
// - Scan code 10 repeats N by count.
// - Scan code 11 converts N once.
// - Setup bits select clock and reference modes.
// - Pair target 10/11 routes next byte.
// - Pair target 00/01 writes no pair register.
// - Pair in both registers counts unipolar.
// - Unipolar straight binary, bipolar two's complement.
// - Averaging up to 32, separate repeat count.
// - Averaging only while enable bit set.
// - External clock mode forces averaging off.
// - Reset bit one clears FIFO only.
// - Reset bit zero restores all defaults.
// - Leading bits select byte type.
// - Input sampled on rising serial clock.
// - Defaults zero, setup clock mode 10.
// - Clock modes 10/11 start scan on write.
`timescale 1ns/1ps
`include "acbd_defs.vh"
module acbd_decoder (
	// Clock and reset.
	input wire ref_clk,
	input wire nrst,
	// Serial port pins.
	input wire cs_n,
	input wire sclk,
	input wire din,
	// Conversion start pin, active low.
	input wire convert_start_pin_n,
	// Conversion request fields.
	output reg [3:0] channel_sel,
	output reg [1:0] scan_pattern,
	output reg temp_request,
	// Scan range and count for the converter.
	output reg [3:0] scan_first,
	output reg [3:0] scan_last,
	output reg [7:0] results_per_scan,
	output reg scan_start,
	// Setup fields.
	output reg [1:0] clock_mode,
	output reg [1:0] reference_mode,
	// Averaging fields.
	output reg averaging_enable,
	output reg averaging_active,
	output reg [1:0] average_count,
	output reg [1:0] repeat_count,
	// Pair registers and the resolved pair polarity.
	output reg [7:0] unipolar_pair_reg,
	output reg [7:0] bipolar_pair_reg,
	output reg [7:0] pair_bipolar_fmt,
	// FIFO clear and full register reset pulses.
	output reg fifo_clear,
	output reg regs_reset
);
	localparam ST_CMD = 2'b01;
	localparam ST_DATA = 2'b10;

	// Synchronised pins.
	wire cs_n_s;
	wire sclk_s;
	wire din_s;
	wire cnv_s;

	// Delayed copies for edge detection.
	reg sclk_d_reg;
	reg cnv_d_reg;

	// Receive state and the pending pair target.
	reg [1:0] state_reg;
	reg [1:0] target_reg;
	reg [2:0] bit_cnt_reg;
	reg [6:0] shift_reg;

	// Command registers.
	reg [7:0] conv_reg;
	reg [7:0] setup_reg;
	reg [7:0] avg_reg;

	// Every pin passes two flip-flops before use; all reset high, the idle level of select and start, so the low-resting clock can only fall,
	// so no false edge follows reset.
	acbd_sync u_sync_cs (.ref_clk(ref_clk), .nrst(nrst), .async_in(cs_n), .rst_val(1'b1), .sync_out(cs_n_s));
	acbd_sync u_sync_sclk (.ref_clk(ref_clk), .nrst(nrst), .async_in(sclk), .rst_val(1'b1), .sync_out(sclk_s));
	acbd_sync u_sync_din (.ref_clk(ref_clk), .nrst(nrst), .async_in(din), .rst_val(1'b1), .sync_out(din_s));
	acbd_sync u_sync_cnv (.ref_clk(ref_clk), .nrst(nrst), .async_in(convert_start_pin_n), .rst_val(1'b1),
		.sync_out(cnv_s));

	// Input bits are taken on the rising serial clock while select is low.
	wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
	wire byte_done = sclk_rise && (bit_cnt_reg == 3'h7);
	wire [7:0] rx_byte = {shift_reg, din_s};
	wire cnv_fall = cnv_d_reg & ~cnv_s;

	// Byte type from the leading bits: the first one bit from the top names the
	// register, so a conversion byte ignores everything below its top bit.
	function [3:0] byte_kind;
		input [7:0] b;
		begin
			if (b[`ACBD_CONV_BIT]) begin
				byte_kind = 4'h1;
			end else if (b[6]) begin
				byte_kind = 4'h2;
			end else if (b[5]) begin
				byte_kind = 4'h4;
			end else if (b[4]) begin
				byte_kind = 4'h8;
			end else begin
				byte_kind = 4'h0;
			end
		end
	endfunction

	wire [3:0] kind = byte_kind(rx_byte);
	wire is_conv = kind[0];
	wire is_setup = kind[1];
	wire is_avg = kind[2];
	wire is_rst = kind[3];
	// Bytes with no leading one are not commands and change nothing.
	wire cmd_byte = byte_done && (state_reg == ST_CMD);
	wire data_byte = byte_done && (state_reg == ST_DATA);
	wire fifo_reset = cmd_byte && is_rst && rx_byte[`ACBD_RST_BIT];
	wire full_reset = cmd_byte && is_rst && !rx_byte[`ACBD_RST_BIT];

	// Scan range and result count for a given request.
	function [15:0] scan_plan;
		input [3:0] n;
		input [1:0] mode;
		input [1:0] nscan;
		input temp;
		reg [7:0] cnt;
		reg [3:0] first;
		reg [3:0] last;
		begin
			cnt = 8'h01;
			first = n;
			last = n;
			case (mode)
				`ACBD_SCAN_LOW: begin
					first = 4'h0;
					cnt = {4'h0, n} + 8'h01;
				end
				`ACBD_SCAN_HIGH: begin
					last = `ACBD_TOP_CH;
					cnt = 8'h10 - {4'h0, n};
				end
				`ACBD_SCAN_REPEAT: begin
					cnt = {4'h0, nscan, 2'b00} + 8'h04;
				end
				default: begin
					cnt = 8'h01;
				end
			endcase
			scan_plan = {first, last, cnt + {7'h00, temp}};
		end
	endfunction

	// Plan of the current request, recomputed whenever the request or the repeat count changes.
	wire [15:0] plan = scan_plan(conv_reg[`ACBD_CH_MSB:`ACBD_CH_LSB],
		conv_reg[`ACBD_SCAN_MSB:`ACBD_SCAN_LSB], avg_reg[1:0], conv_reg[`ACBD_TEMP_BIT]);

	// Clock mode decode: bit 0 marks external clocking, bit 1 a start on write.
	function [1:0] ck_decode;
		input [1:0] mode;
		begin
			ck_decode[0] = (mode == `ACBD_CK_EXT);
			ck_decode[1] = mode[1];
		end
	endfunction

	wire [1:0] ck_flags = ck_decode(setup_reg[`ACBD_CK_MSB:`ACBD_CK_LSB]);
	wire ext_clk = ck_flags[0];
	wire write_start = ck_flags[1];
	reg conv_written_reg;

	// Serial front end: the delayed copies find edges one cycle after the
	// synchronisers, and a high select clears the bit count between frames.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d_reg <= 1'b1;
			cnv_d_reg <= 1'b1;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 7'h00;
		end else begin
			sclk_d_reg <= sclk_s;
			cnv_d_reg <= cnv_s;
			if (cs_n_s) begin
				bit_cnt_reg <= 3'h0;
			end else if (sclk_rise) begin
				shift_reg <= rx_byte[6:0];
				// The three-bit count wraps after the eighth bit, so bytes may follow back to back.
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
			end
		end
	end

	// Command state: a setup byte with a pair target claims the next byte.
	// A high select drops a pending data byte, so a cut frame cannot reach a pair register.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_CMD;
			target_reg <= 2'b00;
		end else if (cs_n_s) begin
			state_reg <= ST_CMD;
		end else if (byte_done) begin
			case (state_reg)
				ST_DATA: begin
					// The data byte itself is taken by the pair registers.
					state_reg <= ST_CMD;
				end
				ST_CMD: begin
					if (is_setup) begin
						target_reg <= rx_byte[1:0];
						if (rx_byte[1]) begin
							state_reg <= ST_DATA;
						end else begin
							state_reg <= ST_CMD;
						end
					end
				end
				default: begin
					state_reg <= ST_CMD;
				end
			endcase
		end
	end

	// Command registers; a full reset command restores the power-up values.
	// Bytes that arrive while a pair data byte is pending never reach them.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			conv_reg <= `ACBD_ZERO_RESET;
			setup_reg <= `ACBD_SETUP_RESET;
			avg_reg <= `ACBD_ZERO_RESET;
		end else if (full_reset) begin
			conv_reg <= `ACBD_ZERO_RESET;
			setup_reg <= `ACBD_SETUP_RESET;
			avg_reg <= `ACBD_ZERO_RESET;
		end else if (cmd_byte) begin
			if (is_conv) begin
				conv_reg <= rx_byte;
			end
			if (is_setup) begin
				setup_reg <= rx_byte;
			end
			if (is_avg) begin
				avg_reg <= rx_byte;
			end
		end
	end

	// Pair registers take only the data byte that directly follows its setup byte.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			unipolar_pair_reg <= `ACBD_ZERO_RESET;
			bipolar_pair_reg <= `ACBD_ZERO_RESET;
		end else if (full_reset) begin
			unipolar_pair_reg <= `ACBD_ZERO_RESET;
			bipolar_pair_reg <= `ACBD_ZERO_RESET;
		end else if (data_byte) begin
			if (target_reg == `ACBD_PAIR_UNI) begin
				unipolar_pair_reg <= rx_byte;
			end else begin
				bipolar_pair_reg <= rx_byte;
			end
		end
	end

	// One-cycle pulses for the FIFO and for the start logic.
	// The scan start waits one more cycle so that it leaves with the new request fields.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fifo_clear <= 1'b0;
			regs_reset <= 1'b0;
			conv_written_reg <= 1'b0;
		end else begin
			fifo_clear <= fifo_reset;
			regs_reset <= full_reset;
			conv_written_reg <= cmd_byte & is_conv;
		end
	end

	// Registered view of the conversion request and its scan plan.
	// The result count already holds the extra temperature result when one is asked for.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			channel_sel <= 4'h0;
			scan_pattern <= 2'b00;
			temp_request <= 1'b0;
			scan_first <= 4'h0;
			scan_last <= 4'h0;
			results_per_scan <= 8'h01;
		end else begin
			channel_sel <= conv_reg[`ACBD_CH_MSB:`ACBD_CH_LSB];
			scan_pattern <= conv_reg[`ACBD_SCAN_MSB:`ACBD_SCAN_LSB];
			temp_request <= conv_reg[`ACBD_TEMP_BIT];
			scan_first <= plan[15:12];
			scan_last <= plan[11:8];
			results_per_scan <= plan[7:0];
		end
	end

	// A written request starts a scan in clock modes 10 and 11; in modes 00 and 01
	// only a low pulse on the start pin does.
	wire start_by_write = conv_written_reg & write_start;
	wire start_by_pin = cnv_fall & ~write_start;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scan_start <= 1'b0;
		end else begin
			scan_start <= start_by_write | start_by_pin;
		end
	end

	// Registered view of the setup, averaging and pair settings.
	// Clock mode 11 clocks the converter from the serial clock, so averaging is masked there.
	// A pair set in both registers stays unipolar.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clock_mode <= 2'b10;
			reference_mode <= 2'b00;
			averaging_enable <= 1'b0;
			averaging_active <= 1'b0;
			average_count <= 2'b00;
			repeat_count <= 2'b00;
			pair_bipolar_fmt <= 8'h00;
		end else begin
			clock_mode <= setup_reg[`ACBD_CK_MSB:`ACBD_CK_LSB];
			reference_mode <= setup_reg[`ACBD_REF_MSB:`ACBD_REF_LSB];
			averaging_enable <= avg_reg[`ACBD_AVG_EN_BIT];
			averaging_active <= avg_reg[`ACBD_AVG_EN_BIT] & ~ext_clk;
			average_count <= avg_reg[3:2];
			repeat_count <= avg_reg[1:0];
			pair_bipolar_fmt <= bipolar_pair_reg & ~unipolar_pair_reg;
		end
	end
endmodule

/* File: src/acbd_defs.vh */
// Constants for the command byte decoder: field positions, codes, reset values.
`ifndef ACBD_DEFS_VH
`define ACBD_DEFS_VH
`define ACBD_CONV_BIT 7
`define ACBD_CH_MSB 6
`define ACBD_CH_LSB 3
`define ACBD_SCAN_MSB 2
`define ACBD_SCAN_LSB 1
`define ACBD_TEMP_BIT 0
`define ACBD_CK_MSB 5
`define ACBD_CK_LSB 4
`define ACBD_REF_MSB 3
`define ACBD_REF_LSB 2
`define ACBD_AVG_EN_BIT 4
`define ACBD_RST_BIT 3
`define ACBD_SCAN_LOW 2'b00
`define ACBD_SCAN_HIGH 2'b01
`define ACBD_SCAN_REPEAT 2'b10
`define ACBD_SCAN_SINGLE 2'b11
`define ACBD_CK_EXT 2'b11
`define ACBD_PAIR_UNI 2'b10
`define ACBD_PAIR_BI 2'b11
`define ACBD_SETUP_RESET 8'h60
`define ACBD_ZERO_RESET 8'h00
`define ACBD_TOP_CH 4'hf
`endif

/* File: src/acbd_sync.v */
// Two flip-flop synchroniser for the serial port pins.
`timescale 1ns/1ps
module acbd_sync (
	// Clock and reset.
	input wire ref_clk,
	input wire nrst,
	// Asynchronous level in, synchronised level out.
	input wire async_in,
	input wire rst_val,
	output reg sync_out
);
	reg meta_reg;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* File: testbench/acbd_chk_sva.sv */
// Checker for the command byte decoder outputs.
`timescale 1ns/1ps
module acbd_chk (
	// Clock and reset.
	input wire ref_clk,
	input wire nrst,
	// Watched ports.
	input wire cs_n,
	input wire [3:0] channel_sel,
	input wire [1:0] scan_pattern,
	input wire temp_request,
	input wire [3:0] scan_first,
	input wire [3:0] scan_last,
	input wire [7:0] results_per_scan,
	input wire [1:0] clock_mode,
	input wire averaging_enable,
	input wire averaging_active,
	input wire [7:0] unipolar_pair_reg,
	input wire [7:0] bipolar_pair_reg,
	input wire [7:0] pair_bipolar_fmt,
	input wire fifo_clear,
	input wire regs_reset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_low; ($stable({channel_sel, scan_pattern}) && scan_pattern == 2'b00)[*2] |->
		scan_first == 4'h0 && scan_last == channel_sel; endproperty
	a_low: assert property (p_low) else $error("low scan range wrong");
	property p_high; ($stable({channel_sel, scan_pattern}) && scan_pattern == 2'b01)[*2] |->
		scan_first == channel_sel && scan_last == 4'hf; endproperty
	a_high: assert property (p_high) else $error("high scan range wrong");
	property p_once; ($stable({scan_pattern, temp_request}) && scan_pattern == 2'b11)[*2] |->
		results_per_scan == 8'h01 + temp_request; endproperty
	a_once: assert property (p_once) else $error("single result count wrong");
	property p_avg; $stable({averaging_enable, clock_mode})[*2] |->
		averaging_active == (averaging_enable && clock_mode != 2'b11); endproperty
	a_avg: assert property (p_avg) else $error("averaging state wrong");
	property p_pair; $stable({unipolar_pair_reg, bipolar_pair_reg})[*2] |->
		pair_bipolar_fmt == (bipolar_pair_reg & ~unipolar_pair_reg); endproperty
	a_pair: assert property (p_pair) else $error("pair format wrong");
	property p_fifo; fifo_clear |=> $stable({clock_mode, unipolar_pair_reg, bipolar_pair_reg})[*2]; endproperty
	a_fifo: assert property (p_fifo) else $error("fifo clear touched setup");
	property p_full; regs_reset |-> ##[0:2] (clock_mode == 2'b10 && {unipolar_pair_reg, bipolar_pair_reg} == 16'h0000);
	endproperty
	a_full: assert property (p_full) else $error("full reset incomplete");
	property p_idle; cs_n[*8] |-> $stable({channel_sel, clock_mode, unipolar_pair_reg}); endproperty
	a_idle: assert property (p_idle) else $error("setup changed while deselected");
endmodule
bind acbd_decoder acbd_chk u_acbd_chk (.*);

/* File: testbench/acbd_host.sv */
// Host serial port model that frames and shifts command bytes.
`timescale 1ns/1ps
module acbd_host (
	// Clock.
	input wire ref_clk,
	// Serial pins.
	output logic cs_n,
	output logic sclk,
	output logic din
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Data moves while the serial clock is low; the clock rests low between frames.
	task automatic put(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			din <= b[i];
			tick(10);
			sclk <= 1'b1;
			tick(10);
			sclk <= 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] b, input bit two);
		cs_n <= 1'b0;
		tick(10);
		put(a);
		if (two) begin
			put(b);
		end
		tick(10);
		din <= ~din;
		cs_n <= 1'b1;
		tick(20);
	endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the command byte decoder.
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic convert_start_pin_n = 1'b1;
	wire cs_n, sclk, din, temp_request, scan_start, averaging_enable, averaging_active, fifo_clear, regs_reset;
	wire [3:0] channel_sel, scan_first, scan_last;
	wire [1:0] scan_pattern, clock_mode, reference_mode, average_count, repeat_count;
	wire [7:0] results_per_scan, unipolar_pair_reg, bipolar_pair_reg, pair_bipolar_fmt;
	logic [7:0] exp_rng [4] = '{8'h05, 8'h5f, 8'h55, 8'h55};
	logic [7:0] exp_res [4] = '{8'h06, 8'h0c, 8'h04, 8'h02};
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int starts = 0;
	int clears = 0;
	int resets = 0;
	acbd_host u_acbd_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din));
	acbd_decoder u_acbd_decoder (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		starts <= starts + int'(scan_start);
		clears <= clears + int'(fifo_clear);
		resets <= resets + int'(regs_reset);
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		check({clock_mode, results_per_scan}, 10'h201);
		for (int m = 0; m < 4; m++) begin
			u_acbd_host.frame({1'b1, 4'h5, m[1:0], m[0]}, 8'h00, 1'b0);
			check(channel_sel, 4'h5);
			check({scan_pattern, temp_request}, {m[1:0], m[0]});
			check({scan_first, scan_last}, exp_rng[m]);
			check(results_per_scan, exp_res[m]);
		end
		check(starts, 4);
		u_acbd_host.frame(8'h7e, 8'ha5, 1'b1);
		u_acbd_host.frame(8'h7f, 8'h3c, 1'b1);
		check({clock_mode, reference_mode}, 4'hf);
		check({unipolar_pair_reg, bipolar_pair_reg}, 16'ha53c);
		check(pair_bipolar_fmt, 8'h18);
		u_acbd_host.frame(8'h3b, 8'h00, 1'b0);
		check({averaging_enable, averaging_active, average_count, repeat_count}, 6'h2b);
		u_acbd_host.frame(8'hac, 8'h00, 1'b0);
		check(results_per_scan, 8'h10);
		u_acbd_host.frame(8'h50, 8'h80, 1'b1);
		check({channel_sel, clock_mode, averaging_active, unipolar_pair_reg}, {4'h0, 2'b01, 1'b1, 8'ha5});
		check(starts, 5);
		convert_start_pin_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		convert_start_pin_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check(starts, 6);
		u_acbd_host.frame(8'h62, 8'h00, 1'b0);
		u_acbd_host.frame(8'h30, 8'h00, 1'b0);
		check({unipolar_pair_reg, averaging_enable}, {8'ha5, 1'b1});
		u_acbd_host.frame(8'h18, 8'h00, 1'b0);
		check(clears, 1);
		check(bipolar_pair_reg, 8'h3c);
		check(resets, 0);
		u_acbd_host.frame(8'h10, 8'h00, 1'b0);
		check({clock_mode, channel_sel, averaging_enable, unipolar_pair_reg, bipolar_pair_reg},
			{2'b10, 4'h0, 1'b0, 16'h0000});
		check(resets, 1);
		finish_test();
	end
endmodule
